/* File: common/eeprom_pkg.sv */
// Shared constants and types for the serial EEPROM command engine
package eeprom_pkg;

  // Array geometry
  localparam int MEM_BYTES  = 256;
  localparam int PAGE_BYTES = 16;
  localparam int ACK_SLOT   = 8;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // Select code type identifiers
  localparam logic [3:0] TYPE_ARRAY = 4'hA;
  localparam logic [3:0] TYPE_PROT  = 4'h6;

  // Self-timed programming cycle
  localparam int CLK_PERIOD_NS        = 10;
  localparam int PROG_CYCLE_TIME_NS   = 1000;
  localparam int PROG_CYCLES_DEF      =
    (PROG_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // APB register map
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_STATUS = 8'h04;
  localparam logic        CTRL_RST   = 1'b1;
  localparam int CTRL_EN_BIT   = 0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_PROT_BIT = 1;
  localparam int STAT_WC_BIT   = 2;
  localparam int STAT_ADDR_LSB = 8;

  // Engine states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SEL  = 6'h02,
    ST_ADDR = 6'h04,
    ST_WDAT = 6'h08,
    ST_RDAT = 6'h10,
    ST_PROG = 6'h20
  } eng_state_t;

endpackage

/* File: rtl/pin_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] out_ff;

  // First stage feeds only the second
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // A bit changes only once stages two and three agree
  always_ff @(posedge mclk) begin
    if (rst) begin
      out_ff <= RST_VAL;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          out_ff[i] <= s3_ff[i];
        end
      end
    end
  end

  assign dout = out_ff;

endmodule // pin_sync
`default_nettype wire

/* File: rtl/prog_timer.sv */
// Self-timed programming cycle counter
`timescale 1ns/1ns
`default_nettype none
module prog_timer #(
  parameter int CYCLES = 100
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_ff;
  logic          busy_ff;

  if (CYCLES < 1) begin : g_bad_cycles
    $error("prog_timer needs at least one cycle");
  end

  // Busy for exactly CYCLES clocks after start
  always_ff @(posedge mclk) begin
    if (rst) begin
      busy_ff <= 1'b0;
      cnt_ff  <= '0;
    end else if (start && !busy_ff) begin
      busy_ff <= 1'b1;
      cnt_ff  <= CW'(CYCLES - 1);
    end else if (busy_ff) begin
      if (cnt_ff == '0) begin
        busy_ff <= 1'b0;
      end else begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  assign busy = busy_ff;
  assign done = busy_ff && (cnt_ff == '0);

endmodule // prog_timer
`default_nettype wire

/* File: rtl/eeprom_engine.sv */
// Two-wire serial EEPROM slave engine with APB status port
//
// Overview of operation
// - Write: select with rw 0, acked, then address acked, then data expected.
// - Programming starts only on Stop right after an ack slot.
// - While programming, both bus lines are ignored, no response.
// - Byte write to protected location gets NoAck, location unchanged.
// - Page write holds one to sixteen bytes of one page.
// - After each page byte only the low four address bits increment.
// - Page bytes acked when write control low; protected ones NoAck'd.
// - While busy, select gets no ack; afterwards it is acked.
// - Reads work whatever the write protection state.
// - One address counter, advanced after every byte read out.
// - Random read: dummy write loads address, repeated Start, read.
// - Current read outputs byte at counter, then increments it.
// - Master ack after a read byte makes the next byte follow.
// - Read counter wraps from last address to zero.
// - No ack in ninth slot after a sent byte returns to standby.
// - Protection register write locks lower 128 bytes for good.
// - Array reads all ones on delivery.
// - Upper select bits choose array or protection; chip bits must match.
// - Write control high protects the whole array.
// - Software protection covers lower half regardless of write control.
// - Once protected, protection select code is no longer answered.
`timescale 1ns/1ns
`default_nettype none
module eeprom_engine
  import eeprom_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        write_control_n,
  input  wire logic        chip_sel_bit0,
  input  wire logic        chip_sel_bit1,
  input  wire logic        chip_sel_bit2,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  // Write blocked for an array address
  function automatic logic is_wprot(input logic [7:0] a, input logic wc,
                                    input logic sw);
    return wc || (sw && !a[7]);
  endfunction

  eng_state_t  state_ff;
  logic [5:0]  pin_f;
  logic        scl_s;
  logic        sda_s;
  logic        wc_s;
  logic [2:0]  cs_s;
  logic        scl_q_ff;
  logic        sda_q_ff;
  logic        rise;
  logic        fall;
  logic        start_ev;
  logic        stop_ev;
  logic [3:0]  bcnt_ff;
  logic        ackslot_ff;
  logic        ack_fall;
  logic        end_fall;
  logic [7:0]  sh_ff;
  logic [7:0]  tx_ff;
  logic [7:0]  addr_ff;
  logic        sda_oe_ff;
  logic        tenth_ff;
  logic        is_prot_ff;
  logic        prot_ff;
  logic        prot_pend_ff;
  logic [15:0] pvalid_ff;
  logic [3:0]  ppage_ff;
  logic [7:0]  pbuf [PAGE_BYTES];
  logic [7:0]  mem [MEM_BYTES];
  logic [7:0]  mem_rd;
  logic        sel_ok;
  logic        wr_blk;
  logic        ack_drv;
  logic        load_tx;
  logic        prog_go;
  logic        prog_start;
  logic        prog_busy;
  logic        prog_done;
  logic        ctrl_en_ff;
  logic [31:0] prdata_ff;
  logic [31:0] stat_w;
  logic        hit_ctrl;
  logic        hit_stat;

  if (PROG_CYCLES < 1) begin : g_bad_prog
    $error("PROG_CYCLES must be at least one");
  end

  // All pins come from the bus side, outside this clock
  pin_sync #(
    .WIDTH   (6),
    .RST_VAL (6'h3F)
  ) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .din  ({scl, sda_in, write_control_n,
            chip_sel_bit2, chip_sel_bit1, chip_sel_bit0}),
    .dout (pin_f)
  );

  assign scl_s = pin_f[5];
  assign sda_s = pin_f[4];
  assign wc_s  = pin_f[3];
  assign cs_s  = pin_f[2:0];

  // Previous line levels for edge and condition detection
  always_ff @(posedge mclk) begin
    if (rst) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
    end
  end

  // Start and Stop need SCL steady high over both samples
  assign rise     = scl_s && !scl_q_ff;
  assign fall     = !scl_s && scl_q_ff;
  assign start_ev = scl_s && scl_q_ff && sda_q_ff && !sda_s;
  assign stop_ev  = scl_s && scl_q_ff && !sda_q_ff && sda_s;
  assign ack_fall = fall && !ackslot_ff && (bcnt_ff == 4'(ACK_SLOT));
  assign end_fall = fall && ackslot_ff;

  // Select decode: type, lock state and chip pins
  assign sel_ok = ((sh_ff[7:4] == TYPE_ARRAY) ||
                   ((sh_ff[7:4] == TYPE_PROT) && !prot_ff)) &&
                  (sh_ff[3:1] == cs_s);
  assign wr_blk = is_prot_ff ? wc_s : is_wprot(addr_ff, wc_s, prot_ff);
  assign mem_rd = mem[addr_ff];

  // Ack decision per phase
  always_comb begin
    ack_drv = 1'b0;
    if (state_ff == ST_SEL) begin
      ack_drv = sel_ok;
    end else if (state_ff == ST_ADDR) begin
      ack_drv = 1'b1;
    end else if (state_ff == ST_WDAT) begin
      ack_drv = !wr_blk;
    end
  end

  // Next byte to send: after a read select or an acked read byte
  assign load_tx = end_fall && (((state_ff == ST_SEL) && sh_ff[0]) ||
                                (state_ff == ST_RDAT));
  assign prog_go    = tenth_ff && ((|pvalid_ff) || prot_pend_ff);
  assign prog_start = (state_ff != ST_PROG) && stop_ev && prog_go;

  prog_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_timer (
    .mclk  (mclk),
    .rst   (rst),
    .start (prog_start),
    .busy  (prog_busy),
    .done  (prog_done)
  );

  // Main bus sequencer; programming blanks it out entirely
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff   <= ST_IDLE;
      bcnt_ff    <= '0;
      ackslot_ff <= 1'b0;
      sh_ff      <= '0;
    end else if (state_ff == ST_PROG) begin
      if (prog_done) begin
        state_ff <= ST_IDLE;
      end
    end else if (stop_ev) begin
      state_ff   <= prog_go ? ST_PROG : ST_IDLE;
      bcnt_ff    <= '0;
      ackslot_ff <= 1'b0;
    end else if (start_ev) begin
      // Repeated Start keeps the counter for a random read
      state_ff   <= ctrl_en_ff ? ST_SEL : ST_IDLE;
      bcnt_ff    <= '0;
      ackslot_ff <= 1'b0;
    end else if (state_ff != ST_IDLE) begin
      if (rise && (bcnt_ff < 4'(ACK_SLOT))) begin
        sh_ff   <= {sh_ff[6:0], sda_s};
        bcnt_ff <= bcnt_ff + 4'h1;
      end
      if (rise && ackslot_ff && (state_ff == ST_RDAT) && sda_s) begin
        state_ff <= ST_IDLE;
      end
      if (ack_fall) begin
        ackslot_ff <= 1'b1;
        if ((state_ff == ST_SEL) && !sel_ok) begin
          state_ff <= ST_IDLE;
        end
      end
      if (end_fall) begin
        ackslot_ff <= 1'b0;
        bcnt_ff    <= '0;
        unique case (state_ff)
          ST_SEL:  state_ff <= sh_ff[0] ? ST_RDAT : ST_ADDR;
          ST_ADDR: state_ff <= ST_WDAT;
          ST_WDAT: state_ff <= ST_WDAT;
          ST_RDAT: state_ff <= ST_RDAT;
          ST_IDLE: state_ff <= ST_IDLE;
          ST_PROG: state_ff <= ST_PROG;
        endcase
      end
    end
  end

  // Tenth slot lasts until the next SCL fall; its own rise must not end it,
  // because the Stop comes while SCL is high after that rise
  always_ff @(posedge mclk) begin
    if (rst) begin
      tenth_ff <= 1'b0;
    end else if (start_ev || stop_ev || (state_ff == ST_PROG)) begin
      tenth_ff <= 1'b0;
    end else if (end_fall && (state_ff == ST_WDAT)) begin
      tenth_ff <= 1'b1;
    end else if (fall) begin
      tenth_ff <= 1'b0;
    end
  end

  // Target latched with the select byte
  always_ff @(posedge mclk) begin
    if (rst) begin
      is_prot_ff <= 1'b0;
    end else if (ack_fall && (state_ff == ST_SEL)) begin
      is_prot_ff <= (sh_ff[7:4] == TYPE_PROT);
    end
  end

  // Single address counter for writes and reads
  always_ff @(posedge mclk) begin
    if (rst) begin
      addr_ff <= '0;
    end else if (ack_fall && (state_ff == ST_ADDR) && !is_prot_ff) begin
      addr_ff <= sh_ff;
    end else if (ack_fall && (state_ff == ST_WDAT)) begin
      addr_ff[3:0] <= addr_ff[3:0] + 4'h1;
    end else if (load_tx) begin
      addr_ff <= addr_ff + 8'h01;
    end
  end

  // Outgoing byte shifter, MSB first
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_ff <= '0;
    end else if (load_tx) begin
      tx_ff <= {mem_rd[6:0], 1'b0};
    end else if (fall && (state_ff == ST_RDAT) && !ackslot_ff &&
                 (bcnt_ff != 4'h0)) begin
      tx_ff <= {tx_ff[6:0], 1'b0};
    end
  end

  // Open-drain data pull; released whenever idle or busy
  always_ff @(posedge mclk) begin
    if (rst) begin
      sda_oe_ff <= 1'b0;
    end else if ((state_ff == ST_IDLE) || (state_ff == ST_PROG) ||
                 start_ev || stop_ev) begin
      sda_oe_ff <= 1'b0;
    end else if (ack_fall) begin
      sda_oe_ff <= ack_drv;
    end else if (load_tx) begin
      sda_oe_ff <= !mem_rd[7];
    end else if (end_fall) begin
      sda_oe_ff <= 1'b0;
    end else if (fall && (state_ff == ST_RDAT) && !ackslot_ff &&
                 (bcnt_ff != 4'h0)) begin
      sda_oe_ff <= !tx_ff[7];
    end
  end

  assign sda_oe  = sda_oe_ff;
  assign sda_out = 1'b0;

  // Page latches: pending flags; dropped by an aborted write
  always_ff @(posedge mclk) begin
    if (rst) begin
      pvalid_ff    <= '0;
      prot_pend_ff <= 1'b0;
      ppage_ff     <= '0;
    end else if (prog_done ||
                 ((state_ff != ST_PROG) &&
                  (start_ev || (stop_ev && !prog_go)))) begin
      pvalid_ff    <= '0;
      prot_pend_ff <= 1'b0;
    end else if (ack_fall && (state_ff == ST_WDAT) && !wr_blk) begin
      if (is_prot_ff) begin
        prot_pend_ff <= 1'b1;
      end else begin
        pvalid_ff[addr_ff[3:0]] <= 1'b1;
        ppage_ff                <= addr_ff[7:4];
      end
    end
  end

  // Page data; rollover overwrites inside the page
  always_ff @(posedge mclk) begin
    if (ack_fall && (state_ff == ST_WDAT) && !wr_blk && !is_prot_ff) begin
      pbuf[addr_ff[3:0]] <= sh_ff;
    end
  end

  // Array commit at the end of the programming cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem[i] <= ERASED_BYTE;
      end
    end else if (prog_done) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (pvalid_ff[i]) begin
          mem[{ppage_ff, 4'(i)}] <= pbuf[i];
        end
      end
    end
  end

  // Lock cannot be cleared by any command
  always_ff @(posedge mclk) begin
    if (rst) begin
      prot_ff <= 1'b0;
    end else if (prog_done && prot_pend_ff) begin
      prot_ff <= 1'b1;
    end
  end

  // APB slave: zero wait states, read data captured in setup
  assign hit_ctrl = (paddr == REG_CTRL);
  assign hit_stat = (paddr == REG_STATUS);
  assign pready   = psel && penable;
  assign pslverr  = psel && penable && !(hit_ctrl || hit_stat);
  assign prdata   = prdata_ff;

  always_comb begin
    stat_w                                 = '0;
    stat_w[STAT_BUSY_BIT]                  = prog_busy;
    stat_w[STAT_PROT_BIT]                  = prot_ff;
    stat_w[STAT_WC_BIT]                    = wc_s;
    stat_w[STAT_ADDR_LSB +: 8]             = addr_ff;
  end

  // Enable gates only new Starts, so a frame in flight completes
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_en_ff <= CTRL_RST;
    end else if (psel && penable && pwrite && hit_ctrl) begin
      ctrl_en_ff <= pwdata[CTRL_EN_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata_ff <= '0;
    end else if (psel && !penable) begin
      if (hit_ctrl) begin
        prdata_ff <= {31'h0, ctrl_en_ff};
      end else if (hit_stat) begin
        prdata_ff <= stat_w;
      end else begin
        prdata_ff <= '0;
      end
    end
  end

  // Checks on the engine
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence tenth_stop;
    tenth_ff && stop_ev && (state_ff != ST_PROG);
  endsequence

  sequence sel_refused;
    ack_fall && (state_ff == ST_SEL) && !sel_ok;
  endsequence

  chk_prog_trigger: assert property (
    (state_ff != ST_PROG) && stop_ev && !tenth_ff |=> !prog_busy)
    else $error("programming started outside the tenth slot");
  chk_prog_launch: assert property (
    tenth_stop ##0 ((|pvalid_ff) || prot_pend_ff) |=> prog_busy && (state_ff == ST_PROG))
    else $error("tenth-slot Stop did not start programming");
  chk_busy_quiet: assert property ((state_ff == ST_PROG) |-> !sda_oe_ff)
    else $error("data line pulled while programming");
  chk_protect_nack: assert property (
    ack_fall && (state_ff == ST_WDAT) && wr_blk |=> !sda_oe_ff)
    else $error("protected byte was acknowledged");
  chk_open_ack: assert property (
    ack_fall && (state_ff == ST_WDAT) && !wr_blk |=> sda_oe_ff)
    else $error("writable byte not acknowledged");
  chk_page_wrap: assert property (
    ack_fall && (state_ff == ST_WDAT) |=>
      (addr_ff[7:4] == $past(addr_ff[7:4])) &&
      (addr_ff[3:0] == $past(addr_ff[3:0]) + 4'h1))
    else $error("page address step wrong");
  chk_read_incr: assert property (
    load_tx |=> addr_ff == $past(addr_ff) + 8'h01)
    else $error("read counter did not advance");
  chk_sel_reject: assert property (
    sel_refused |=> (state_ff == ST_IDLE) && !sda_oe_ff)
    else $error("mismatched select was answered");
  chk_nack_standby: assert property (
    rise && ackslot_ff && (state_ff == ST_RDAT) && sda_s |=>
      (state_ff == ST_IDLE) ##1 !sda_oe_ff)
    else $error("read continued after master NoAck");
  chk_lock_keep: assert property (prot_ff |=> prot_ff)
    else $error("software protection was cleared");
  chk_done_idle: assert property (prog_done |=> state_ff == ST_IDLE)
    else $error("no standby after programming");
  chk_prot_gone: assert property (
    prot_ff && ack_fall && (state_ff == ST_SEL) &&
      (sh_ff[7:4] == TYPE_PROT) |=> !sda_oe_ff)
    else $error("locked protection code was answered");

endmodule // eeprom_engine
`default_nettype wire

/* File: verif/i2c_master_model.sv */
// Behavioural two-wire bus master that drives the engine's serial pins
`timescale 1ns/1ns
`default_nettype none
module i2c_master_model (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      drv_low
);
  // Bus idles released; SCL stands high between frames
  initial begin
    scl = 1'b1;
    drv_low = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // One bit slot; SCL low 12 clocks to cover the pin filter latency
  task automatic xbit(input logic b, output logic r);
    drv_low <= ~b;
    hold(6);
    scl <= 1'b1;
    hold(6);
    r = sda;
    hold(6);
    scl <= 1'b0;
    hold(6);
  endtask

  // Also serves as repeated Start, since it releases SDA first
  task automatic start();
    drv_low <= 1'b0;
    hold(6);
    scl <= 1'b1;
    hold(10);
    drv_low <= 1'b1;
    hold(10);
    scl <= 1'b0;
    hold(6);
  endtask

  task automatic stop();
    drv_low <= 1'b1;
    hold(6);
    scl <= 1'b1;
    hold(10);
    drv_low <= 1'b0;
    hold(10);
  endtask

  // Byte out MSB first, then ninth slot released for the device
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], r);
    end
    xbit(1'b1, r);
    ack = ~r;
  endtask

  // Byte in; master acks to continue, withholds ack on the last byte
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xbit(1'b1, d[i]);
    end
    xbit(~mack, r);
  endtask
endmodule // i2c_master_model
`default_nettype wire

/* File: verif/serial_eeprom_rw_engine_tb_top.sv */
// Self-checking bench for the serial EEPROM command engine
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_rw_engine_tb_top;
  import eeprom_pkg::*;
  localparam int         PROG = 400;
  localparam logic [2:0] CS   = 3'b101;
  logic        mclk;
  logic        rst;
  logic        wc_n;
  logic [2:0]  cs_pins;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        scl;
  logic        drv_low;
  logic        sda_oe;
  logic        sda_out;
  logic [31:0] q;
  logic        e;
  int          mismatches;
  int          n_compared;
  // Open drain: pull-up wins unless someone pulls low
  wire logic   sda = ~drv_low & (sda_oe ? sda_out : 1'b1);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  eeprom_engine #(.PROG_CYCLES(PROG)) uut (
    .mclk(mclk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .write_control_n(wc_n), .chip_sel_bit0(cs_pins[0]), .chip_sel_bit1(cs_pins[1]),
    .chip_sel_bit2(cs_pins[2]), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  i2c_master_model m (.mclk(mclk), .sda(sda), .scl(scl), .drv_low(drv_low));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // APB cycle; holds the request until pready, only the watchdog ends a wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic sel(input logic [3:0] ty, input logic rw, input logic x);
    logic ack;
    m.start();
    m.wbyte({ty, CS, rw}, ack);
    chk(32'(ack), 32'(x));
  endtask

  task automatic wb(input logic [7:0] d, input logic x);
    logic ack;
    m.wbyte(d, ack);
    chk(32'(ack), 32'(x));
  endtask

  // Dummy write then repeated Start; n bytes expected, first in bits 31:24
  task automatic rand_rd(input logic [7:0] a, input int n, input logic [31:0] x);
    logic [7:0] d;
    sel(TYPE_ARRAY, 1'b0, 1'b1);
    wb(a, 1'b1);
    sel(TYPE_ARRAY, 1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      m.rbyte(i < n - 1, d);
      chk({24'h0, d}, {24'h0, x[31 - 8 * i -: 8]});
    end
    m.stop();
  endtask

  task automatic t_fresh();
    apb(1'b0, REG_STATUS, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, REG_CTRL, 32'h0);
    chk(q, 32'h1);
    apb(1'b0, 8'h08, 32'h0);
    chk({31'h0, e}, 32'h1);
    rand_rd(8'h05, 1, {ERASED_BYTE, 24'h0});
    $display("t_fresh done");
  endtask

  // Page write crossing the page end wraps to the page start
  task automatic t_page();
    logic ack;
    logic r;
    int   n;
    sel(TYPE_ARRAY, 1'b0, 1'b1);
    wb(8'h0E, 1'b1);
    wb(8'hA1, 1'b1);
    wb(8'hB2, 1'b1);
    wb(8'hC3, 1'b1);
    m.stop();
    apb(1'b0, REG_STATUS, 32'h0);
    chk(q & 32'h1, 32'h1);
    sel(TYPE_ARRAY, 1'b0, 1'b0);
    // Poll until answered; a Start that falls inside the cycle is lost
    n = 0;
    do begin
      m.start();
      m.wbyte({TYPE_ARRAY, CS, 1'b0}, ack);
      n++;
    end while (!ack && n < 8);
    chk(32'(ack), 32'h1);
    // Stop one bit into the next byte must not program
    wb(8'h30, 1'b1);
    wb(8'h99, 1'b1);
    m.xbit(1'b0, r);
    m.stop();
    apb(1'b0, REG_STATUS, 32'h0);
    chk(q & 32'h1, 32'h0);
    rand_rd(8'h0E, 3, 32'hA1B2FF00);
    rand_rd(8'h00, 1, 32'hC3000000);
    rand_rd(8'h30, 1, 32'hFF000000);
    $display("t_page done");
  endtask

  task automatic t_reads();
    logic [7:0] d;
    rand_rd(8'hFF, 2, 32'hFFC30000);
    sel(TYPE_ARRAY, 1'b1, 1'b1);
    m.rbyte(1'b0, d);
    chk({24'h0, d}, 32'hFF);
    m.stop();
    apb(1'b0, REG_STATUS, 32'h0);
    chk(q & 32'hFF00, 32'h0200);
    $display("t_reads done");
  endtask

  task automatic t_protect();
    wc_n <= 1'b1;
    sel(TYPE_ARRAY, 1'b0, 1'b1);
    wb(8'h20, 1'b1);
    wb(8'h55, 1'b0);
    m.stop();
    rand_rd(8'h20, 1, 32'hFF000000);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(q & 32'h4, 32'h4);
    wc_n <= 1'b0;
    sel(TYPE_PROT, 1'b0, 1'b1);
    wb(8'h00, 1'b1);
    wb(8'h00, 1'b1);
    m.stop();
    repeat (PROG + 20) @(posedge mclk);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(q & 32'h2, 32'h2);
    sel(TYPE_PROT, 1'b0, 1'b0);
    sel(TYPE_ARRAY, 1'b0, 1'b1);
    wb(8'h10, 1'b1);
    wb(8'h77, 1'b0);
    sel(TYPE_ARRAY, 1'b0, 1'b1);
    wb(8'h90, 1'b1);
    wb(8'h5A, 1'b1);
    m.stop();
    repeat (PROG + 20) @(posedge mclk);
    rand_rd(8'h90, 1, 32'h5A000000);
    rand_rd(8'h10, 1, 32'hFF000000);
    $display("t_protect done");
  endtask

  // Wrong chip bits and a disabled engine both leave select unanswered
  task automatic t_refuse();
    logic ack;
    m.start();
    m.wbyte({TYPE_ARRAY, ~CS, 1'b0}, ack);
    chk(32'(ack), 32'h0);
    m.stop();
    // Moved chip pins make that same select code match
    cs_pins <= ~CS;
    m.start();
    m.wbyte({TYPE_ARRAY, ~CS, 1'b0}, ack);
    chk(32'(ack), 32'h1);
    m.stop();
    cs_pins <= CS;
    apb(1'b1, REG_CTRL, 32'h0);
    sel(TYPE_ARRAY, 1'b0, 1'b0);
    m.stop();
    apb(1'b1, REG_CTRL, 32'h1);
    sel(TYPE_ARRAY, 1'b0, 1'b1);
    m.stop();
    $display("t_refuse done");
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    wc_n = 1'b0;
    cs_pins = CS;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mismatches = 0;
    n_compared = 0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (6) @(posedge mclk);
    t_fresh();
    t_page();
    t_reads();
    t_protect();
    t_refuse();
    report_and_stop();
  end

  // Watchdog; the full run needs just under a fifth of this
  initial begin
    #900000;
    mismatches++;
    report_and_stop();
  end
endmodule // serial_eeprom_rw_engine_tb_top
`default_nettype wire
